// *** hdl/nfa_pkg.sv ***
// constants, types and helpers shared by the feature-access host controller
// What this block does
// - command EFh writes, EEh reads, four parameters at one feature address byte
// - host gives exactly one feature address cycle before parameter bytes
// - host waits address_to_data_delay after the address before first parameter
// - one parameter byte per write strobe rising edge, four bytes, P1 first
// - after fourth byte target is busy feature_busy_time; 70h may poll completion
// - host that polled with 70h issues 00h before reading parameter bytes
// - host never issues addressed_status_command around feature read output
// - after busy ends host enables output and reads P1 to P4 in order
package nfa_pkg;

    localparam logic [7:0] CMD_SET_FEAT         = 8'hEF;
    localparam logic [7:0] CMD_GET_FEAT         = 8'hEE;
    localparam logic [7:0] CMD_READ_STATUS      = 8'h70;
    localparam logic [7:0] CMD_ADDRESSED_STATUS = 8'h78;

    localparam logic [7:0] FA_TIMING_MODE = 8'h01;
    localparam logic [7:0] FA_DRIVE       = 8'h80;
    localparam logic [7:0] FA_RB_PULLDOWN = 8'h81;
    localparam logic [7:0] FA_ARRAY_MODE  = 8'h90;

    localparam logic [7:0] MASK_TIMING_P1 = 8'h07;
    localparam logic [7:0] MASK_STRENGTH  = 8'h03;
    localparam logic [7:0] MASK_ARRAY_P1  = 8'h03;

    localparam int          NUM_PARAMS  = 4;
    localparam int          SYNC_STAGES = 2;
    localparam int unsigned CLK_NS      = 5;

    // bus phase minima and busy maxima in ns
    localparam int unsigned WE_LOW_NS                  = 25;
    localparam int unsigned WE_HIGH_NS                 = 15;
    localparam int unsigned RE_LOW_NS                  = 25;
    localparam int unsigned RE_HIGH_NS                 = 15;
    localparam int unsigned ADDRESS_TO_DATA_DELAY_NS   = 70;
    localparam int unsigned WE_TO_BUSY_NS              = 100;
    localparam int unsigned FEATURE_BUSY_TIME_NS       = 1000;
    localparam int unsigned INTERFACE_CHANGE_BUSY_NS   = 2000;

    // least times round up, longest round down
    localparam logic [15:0] WE_LOW_CYC  = 16'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WE_HIGH_CYC = 16'((WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RE_LOW_CYC  = 16'((RE_LOW_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [15:0] RE_HIGH_CYC = 16'((RE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] ADL_CYC     = 16'((ADDRESS_TO_DATA_DELAY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WB_CYC      = 16'((WE_TO_BUSY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [15:0] FEAT_CYC    = 16'(FEATURE_BUSY_TIME_NS / CLK_NS);
    localparam logic [15:0] ITC_CYC     = 16'(INTERFACE_CHANGE_BUSY_NS / CLK_NS);

    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT_IDLE, ST_CMD, ST_ADDR, ST_ADL, ST_WDATA, ST_WB, ST_BUSY, ST_RDATA, ST_DONE
    } nfa_state_t;

    function automatic logic addr_known(input logic [7:0] fa);
        addr_known = (fa == FA_TIMING_MODE) || (fa == FA_DRIVE) || (fa == FA_RB_PULLDOWN) || (fa == FA_ARRAY_MODE);
    endfunction : addr_known

    function automatic logic [7:0] p1_mask(input logic [7:0] fa);
        if (fa == FA_TIMING_MODE) begin
            p1_mask = MASK_TIMING_P1;
        end else if (fa == FA_ARRAY_MODE) begin
            p1_mask = MASK_ARRAY_P1;
        end else begin
            p1_mask = MASK_STRENGTH;
        end
    endfunction : p1_mask

endpackage : nfa_pkg

// *** hdl/nfa_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nfa_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : nfa_sync

// *** hdl/nfa_feature_host.sv ***
// host controller issuing feature write and read sequences on the async flash bus
`timescale 1ns/1ps
module nfa_feature_host (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        cmd_valid_in,
    output logic             cmd_ready_out,
    input  wire logic        cmd_write_in,
    input  wire logic [7:0]  cmd_addr_in,
    input  wire logic [31:0] cmd_wdata_in,
    output logic [31:0]      rdata_out,
    output logic             done_out,
    output logic             error_out,
    output logic             nand_ce_n_out,
    output logic             nand_cle_out,
    output logic             nand_ale_out,
    output logic             nand_we_n_out,
    output logic             nand_re_n_out,
    output logic [7:0]       nand_io_out,
    output logic             nand_io_oe_out,
    input  wire logic [7:0]  nand_io_in,
    input  wire logic        nand_rb_n_in
);
    import nfa_pkg::*;

    nfa_state_t  state_reg, state_next;
    logic        phase_reg, phase_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [1:0]  idx_reg, idx_next;
    logic        write_reg, write_next;
    logic [7:0]  addr_reg, addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        done_reg, done_next;
    logic        error_reg, error_next;
    logic        ce_n_reg, ce_n_next;
    logic        cle_reg, cle_next;
    logic        ale_reg, ale_next;
    logic        we_n_reg, we_n_next;
    logic        re_n_reg, re_n_next;
    logic [7:0]  io_reg, io_next;
    logic        oe_reg, oe_next;

    logic [7:0]  io_sync;
    logic        rb_sync;
    logic [15:0] busy_limit;
    logic        strobe_end;
    logic [31:0] wdata_clean;

    nfa_sync #(.WIDTH(8)) u_io_sync (
        .clk_in    (clk_in),
        .reset_n_in(reset_n_in),
        .async_in  (nand_io_in),
        .sync_out  (io_sync)
    );

    nfa_sync #(.WIDTH(1)) u_rb_sync (
        .clk_in    (clk_in),
        .reset_n_in(reset_n_in),
        .async_in  (nand_rb_n_in),
        .sync_out  (rb_sync)
    );

    always_comb begin
        // reserved bits and bytes forced to zero before they reach the pins
        wdata_clean = {24'h00_0000, cmd_wdata_in[7:0] & p1_mask(cmd_addr_in)};
        // an interface change may keep the target busy longer
        busy_limit  = (write_reg && addr_reg == FA_TIMING_MODE) ? ITC_CYC : FEAT_CYC;
        strobe_end  = phase_reg && (cnt_reg == ((state_reg == ST_RDATA) ? RE_HIGH_CYC : WE_HIGH_CYC) - 16'h0001);

        state_next = state_reg;
        phase_next = phase_reg;
        cnt_next   = cnt_reg + 16'h0001;
        idx_next   = idx_reg;
        write_next = write_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = 1'b0;
        error_next = 1'b0;

        case (state_reg)
            ST_IDLE: begin
                cnt_next   = 16'h0000;
                phase_next = 1'b0;
                idx_next   = 2'b00;
                if (cmd_valid_in) begin
                    write_next = cmd_write_in;
                    addr_next  = cmd_addr_in;
                    wdata_next = wdata_clean;
                    if (cmd_write_in && !addr_known(cmd_addr_in)) begin
                        // refused locally: reserved addresses are never written
                        error_next = 1'b1;
                        done_next  = 1'b1;
                    end else begin
                        state_next = ST_WAIT_IDLE;
                    end
                end
            end
            ST_WAIT_IDLE: begin
                if (rb_sync) begin
                    // only start while the target reports idle
                    state_next = ST_CMD;
                    cnt_next   = 16'h0000;
                end else if (cnt_reg >= busy_limit) begin
                    error_next = 1'b1;
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_CMD, ST_ADDR, ST_WDATA: begin
                if (!phase_reg && cnt_reg == WE_LOW_CYC - 16'h0001) begin
                    phase_next = 1'b1;
                    cnt_next   = 16'h0000;
                end else if (strobe_end) begin
                    phase_next = 1'b0;
                    cnt_next   = 16'h0000;
                    if (state_reg == ST_CMD) begin
                        state_next = ST_ADDR;
                    end else if (state_reg == ST_ADDR) begin
                        // single address cycle, then data or busy
                        state_next = write_reg ? ST_ADL : ST_WB;
                    end else begin
                        idx_next = idx_reg + 2'b01;
                        if (idx_reg == 2'(NUM_PARAMS - 1)) begin
                            state_next = ST_WB;
                        end
                    end
                end
            end
            ST_ADL: begin
                if (cnt_reg == ADL_CYC - 16'h0001) begin
                    state_next = ST_WDATA;
                    cnt_next   = 16'h0000;
                end
            end
            ST_WB: begin
                // let the ready pin fall and cross the synchroniser first
                if (cnt_reg == WB_CYC - 16'h0001) begin
                    state_next = ST_BUSY;
                    cnt_next   = 16'h0000;
                end
            end
            ST_BUSY: begin
                if (rb_sync) begin
                    // ready pin replaces 70h polling, so no 00h is ever needed
                    state_next = write_reg ? ST_DONE : ST_RDATA;
                    cnt_next   = 16'h0000;
                    idx_next   = 2'b00;
                    phase_next = 1'b0;
                end else if (cnt_reg >= busy_limit) begin
                    // error has to stand in the same cycle as done
                    error_next = 1'b1;
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_RDATA: begin
                if (!phase_reg && cnt_reg == RE_LOW_CYC - 16'h0001) begin
                    // sample late enough to cover the two input flops
                    rdata_next[8*idx_reg +: 8] = io_sync;
                    phase_next = 1'b1;
                    cnt_next   = 16'h0000;
                end else if (strobe_end) begin
                    phase_next = 1'b0;
                    cnt_next   = 16'h0000;
                    idx_next   = idx_reg + 2'b01;
                    if (idx_reg == 2'(NUM_PARAMS - 1)) begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // pins follow the next state so they leave flip-flops glitch free
        ce_n_next = (state_next == ST_IDLE) || (state_next == ST_WAIT_IDLE) || (state_next == ST_DONE);
        cle_next  = (state_next == ST_CMD);
        ale_next  = (state_next == ST_ADDR);
        oe_next   = (state_next == ST_CMD) || (state_next == ST_ADDR) || (state_next == ST_WDATA);
        we_n_next = !(oe_next && !phase_next);
        re_n_next = !((state_next == ST_RDATA) && !phase_next);
        if (state_next == ST_CMD) begin
            io_next = write_next ? CMD_SET_FEAT : CMD_GET_FEAT;
        end else if (state_next == ST_ADDR) begin
            io_next = addr_next;
        end else if (state_next == ST_WDATA) begin
            io_next = wdata_next[8*idx_next +: 8];
        end else begin
            io_next = 8'h00;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_IDLE;
            phase_reg <= 1'b0;
            cnt_reg   <= 16'h0000;
            idx_reg   <= 2'b00;
            write_reg <= 1'b0;
            addr_reg  <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            done_reg  <= 1'b0;
            error_reg <= 1'b0;
            ce_n_reg  <= 1'b1;
            cle_reg   <= 1'b0;
            ale_reg   <= 1'b0;
            we_n_reg  <= 1'b1;
            re_n_reg  <= 1'b1;
            io_reg    <= 8'h00;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            idx_reg   <= idx_next;
            write_reg <= write_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg  <= done_next;
            error_reg <= error_next;
            ce_n_reg  <= ce_n_next;
            cle_reg   <= cle_next;
            ale_reg   <= ale_next;
            we_n_reg  <= we_n_next;
            re_n_reg  <= re_n_next;
            io_reg    <= io_next;
            oe_reg    <= oe_next;
        end
    end

    assign cmd_ready_out  = (state_reg == ST_IDLE);
    assign rdata_out      = rdata_reg;
    assign done_out       = done_reg;
    assign error_out      = error_reg;
    assign nand_ce_n_out  = ce_n_reg;
    assign nand_cle_out   = cle_reg;
    assign nand_ale_out   = ale_reg;
    assign nand_we_n_out  = we_n_reg;
    assign nand_re_n_out  = re_n_reg;
    assign nand_io_out    = io_reg;
    assign nand_io_oe_out = oe_reg;

    // helper counters read only by the checks below
    logic [1:0]  ale_cnt_reg;
    logic [2:0]  data_cnt_reg;
    logic [15:0] gap_cnt_reg;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ale_cnt_reg  <= 2'b00;
            data_cnt_reg <= 3'b000;
            gap_cnt_reg  <= 16'h0000;
        end else begin
            ale_cnt_reg  <= (state_reg == ST_IDLE) ? 2'b00 : ale_cnt_reg + 2'((ale_next && !we_n_next && we_n_reg));
            data_cnt_reg <= (state_reg == ST_IDLE) ? 3'b000
                          : data_cnt_reg + 3'((state_next == ST_WDATA) && !we_n_next && we_n_reg);
            gap_cnt_reg  <= (!we_n_reg) ? 16'h0000 : ((gap_cnt_reg == 16'hFFFF) ? gap_cnt_reg : gap_cnt_reg + 16'h0001);
        end
    end

    chk_cmd_code: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cle_reg && !we_n_reg) |-> (io_reg == CMD_SET_FEAT || io_reg == CMD_GET_FEAT))
        else $error("command cycle carries an unexpected code");
    chk_addr_once: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ale_cnt_reg <= 2'b01)
        else $error("more than one address cycle in a feature sequence");
    chk_adl_gap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ($fell(we_n_reg) && state_reg == ST_WDATA && idx_reg == 2'b00) |-> $past(gap_cnt_reg) >= ADL_CYC)
        else $error("first parameter byte too soon after the address");
    chk_four_bytes: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_reg == ST_WB && $past(state_reg) == ST_WDATA) |-> data_cnt_reg == 3'd4)
        else $error("feature write did not strobe exactly four bytes");
    chk_busy_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_reg == ST_BUSY && rb_sync) |=> (state_reg == ST_DONE || state_reg == ST_RDATA) && we_n_reg)
        else $error("ready not followed promptly after busy");
    chk_no_poll: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cle_reg |-> io_reg != CMD_READ_STATUS)
        else $error("status poll issued during a feature sequence");
    chk_no_addr_status: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cle_reg |-> io_reg != CMD_ADDRESSED_STATUS)
        else $error("addressed status command issued around feature read");
    chk_read_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(re_n_reg) |-> (state_reg == ST_RDATA && !write_reg) ##0 !re_n_reg [*7] ##1 re_n_reg)
        else $error("read strobe outside read phase or wrong width");
    chk_reserved_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_reg == ST_WDATA && !we_n_reg) |->
            (idx_reg == 2'b00 ? ((io_reg & ~p1_mask(addr_reg)) == 8'h00) : (io_reg == 8'h00)))
        else $error("reserved bits driven nonzero");

    cov_write_done: cover property (@(posedge clk_in) disable iff (!reset_n_in) done_reg && write_reg && !error_reg);
    cov_read_done:  cover property (@(posedge clk_in) disable iff (!reset_n_in) done_reg && !write_reg && !error_reg);
    cov_refused:    cover property (@(posedge clk_in) disable iff (!reset_n_in) done_reg && error_reg);
    cov_itc_write:  cover property (@(posedge clk_in) disable iff (!reset_n_in)
        state_reg == ST_BUSY && write_reg && addr_reg == FA_TIMING_MODE);
endmodule : nfa_feature_host

// *** sim/nfa_dev_model.sv ***
// behavioural flash target answering feature write and read commands
`timescale 1ns/1ps
module nfa_dev_model
    import nfa_pkg::*;
#(
    // one bit per timing mode the parameter page advertises
    parameter logic [7:0] MODES_ADVERTISED = 8'h3F
) (
    input  wire logic        ce_n_in,
    input  wire logic        cle_in,
    input  wire logic        ale_in,
    input  wire logic        we_n_in,
    input  wire logic        re_n_in,
    input  wire logic [7:0]  io_in,
    input  wire logic [15:0] busy_ns_in,
    input  wire logic        hold_busy_in,
    output logic      [7:0]  io_out,
    output logic             rb_n_out
);
    logic [7:0]  cmd_reg;
    logic [7:0]  fa_reg;
    logic [31:0] wbuf_reg;
    logic [31:0] feat_mem [4];
    logic        ready_reg;
    int          idx;

    function automatic int slot(input logic [7:0] fa);
        case (fa)
            FA_TIMING_MODE: slot = 0;
            FA_DRIVE:       slot = 1;
            FA_RB_PULLDOWN: slot = 2;
            FA_ARRAY_MODE:  slot = 3;
            default:        slot = -1;
        endcase
    endfunction : slot

    // power-on: mode 0, full strengths, normal array operation
    initial begin
        foreach (feat_mem[i]) feat_mem[i] = 32'h0000_0000;
        ready_reg = 1'b1;
        cmd_reg = 8'h00;
        fa_reg = 8'h00;
        io_out = 8'h00;
        idx = 0;
    end

    // held busy stands for another die still working
    assign rb_n_out = ready_reg && !hold_busy_in;

    task automatic go_busy(input int ns);
        ready_reg = 1'b0;
        #(ns);
        ready_reg = 1'b1;
    endtask : go_busy

    always @(posedge we_n_in) begin
        if (!ce_n_in && cle_in) begin
            cmd_reg = io_in;
            idx = 0;
        end else if (!ce_n_in && ale_in) begin
            fa_reg = io_in;
            idx = 0;
            if (cmd_reg == CMD_GET_FEAT) go_busy(busy_ns_in);
        end else if (!ce_n_in && cmd_reg == CMD_SET_FEAT && idx < NUM_PARAMS) begin
            wbuf_reg[idx*8 +: 8] = io_in;
            idx++;
            if (idx == NUM_PARAMS) begin
                // a mode outside the advertised set is not taken
                if (slot(fa_reg) >= 0 && (fa_reg != FA_TIMING_MODE || MODES_ADVERTISED[wbuf_reg[2:0]])) begin
                    feat_mem[slot(fa_reg)] = wbuf_reg;
                end
                go_busy(busy_ns_in);
            end
        end
    end

    // reserved addresses read back as zero
    always @(negedge re_n_in) begin
        if (!ce_n_in) io_out = (slot(fa_reg) >= 0) ? feat_mem[slot(fa_reg)][(idx%4)*8 +: 8] : 8'h00;
    end

    // released bus shows the inverse, not a stale byte
    always @(posedge re_n_in) begin
        idx++;
        io_out = ~io_out;
    end
endmodule : nfa_dev_model

// *** sim/nfa_feature_host_test.sv ***
// self-checking bench for the feature-access host controller
`timescale 1ns/1ps
module nfa_feature_host_test;
    import nfa_pkg::*;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        valid = 1'b0;
    logic        ready;
    logic        wr = 1'b0;
    logic [7:0]  fa = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rd;
    logic        done;
    logic        err;
    logic        ce_n, cle, ale, we_n, re_n, oe, rb_n;
    logic [7:0]  io_h, io_d;
    logic [15:0] busy_ns = 16'h012C;
    logic        hold = 1'b0;
    wire  [7:0]  io_bus = oe ? io_h : io_d;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          wes = 0;
    int          res = 0;

    always #2.5 clk_in = ~clk_in;

    nfa_feature_host u_nfa_feature_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(valid),
        .cmd_ready_out(ready), .cmd_write_in(wr), .cmd_addr_in(fa), .cmd_wdata_in(wd), .rdata_out(rd),
        .done_out(done), .error_out(err), .nand_ce_n_out(ce_n), .nand_cle_out(cle), .nand_ale_out(ale),
        .nand_we_n_out(we_n), .nand_re_n_out(re_n), .nand_io_out(io_h), .nand_io_oe_out(oe),
        .nand_io_in(io_bus), .nand_rb_n_in(rb_n));
    nfa_dev_model u_nfa_dev_model (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n), .re_n_in(re_n),
        .io_in(io_bus), .busy_ns_in(busy_ns), .hold_busy_in(hold), .io_out(io_d), .rb_n_out(rb_n));

    always @(posedge we_n) wes++;
    always @(negedge re_n) res++;

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    // the run is about 4k cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic request(input logic w, input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        int n;
        n = 0;
        @(negedge clk_in);
        wes = 0;
        res = 0;
        valid = 1'b1;
        wr = w;
        fa = a;
        wd = d;
        while (ready !== 1'b1) @(negedge clk_in);
        @(negedge clk_in);
        valid = 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        check("done", 1'b1, done);
        check("ready with done", 1'b1, ready);
        check("error", exp_err, err);
        @(negedge clk_in);
        check("done pulse", 1'b0, done);
    endtask : request

    task automatic read_expect(input logic [7:0] a, input logic [31:0] exp);
        request(1'b0, a, 32'h0000_0000, 1'b0);
        check("read command", CMD_GET_FEAT, u_nfa_dev_model.cmd_reg);
        check("read strobes", 2, wes);
        check("read bytes", 4, res);
        check("read data", exp, rd);
    endtask : read_expect

    task automatic test_defaults;
        logic [7:0] addrs [4] = '{FA_TIMING_MODE, FA_DRIVE, FA_RB_PULLDOWN, FA_ARRAY_MODE};
        foreach (addrs[i]) read_expect(addrs[i], 32'h0000_0000);
    endtask : test_defaults

    task automatic test_write_back;
        logic [7:0]  ta [6] = '{8'h01, 8'h80, 8'h81, 8'h90, 8'h90, 8'h80};
        logic [31:0] td [6] = '{32'hAABB_CCFD, 32'h0000_0001, 32'h1100_0002, 32'h0000_0003, 32'h0000_0001,
                                32'h0000_0003};
        logic [7:0]  te [6] = '{8'h05, 8'h01, 8'h02, 8'h03, 8'h01, 8'h03};
        foreach (ta[i]) begin
            request(1'b1, ta[i], td[i], 1'b0);
            check("write command", CMD_SET_FEAT, u_nfa_dev_model.cmd_reg);
            check("write strobes", 6, wes);
            check("param bytes", {24'h00_0000, te[i]}, u_nfa_dev_model.wbuf_reg);
            read_expect(ta[i], {24'h00_0000, te[i]});
        end
    endtask : test_write_back

    task automatic test_reserved;
        request(1'b1, 8'h02, 32'h0000_0001, 1'b1);
        check("refused strobes", 0, wes);
        read_expect(8'h55, 32'h0000_0000);
    endtask : test_reserved

    task automatic test_idle_wait(input int hold_cyc, input logic exp_err);
        hold = 1'b1;
        fork
            request(1'b1, FA_DRIVE, 32'h0000_0000, exp_err);
            begin
                repeat (hold_cyc) @(negedge clk_in);
                check("enable while busy", 1'b1, ce_n);
                hold = 1'b0;
            end
        join
    endtask : test_idle_wait

    task automatic test_slow;
        busy_ns = 16'h04B0;
        request(1'b1, FA_DRIVE, 32'h0000_0002, 1'b1);
        request(1'b1, FA_TIMING_MODE, 32'h0000_0001, 1'b0);
        request(1'b0, FA_DRIVE, 32'h0000_0000, 1'b1);
        busy_ns = 16'h012C;
        read_expect(FA_TIMING_MODE, 32'h0000_0001);
    endtask : test_slow

    initial begin
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        test_defaults();
        test_write_back();
        test_reserved();
        test_idle_wait(100, 1'b0);
        test_idle_wait(260, 1'b1);
        test_slow();
        conclude();
    end
endmodule : nfa_feature_host_test
